// ==== logic/ecc_current_ctrl.sv ====
// Current-source control register on the SFR bus, with analog control outputs
`timescale 1ns/1ps
`include "ecc_regs.svh"
module ecc_current_ctrl (
  input wire logic mclk, // Core clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [7:0] sfrAddr, // SFR address
  input wire logic [7:0] sfrWdata, // SFR write data
  input wire logic sfrWrite, // Byte write strobe
  input wire logic sfrRead, // Byte read strobe
  input wire logic sfrBitOp, // Bit-addressed access marker
  output logic [7:0] sfrRdata, // Read data, zero when not selected
  output logic sfrRdValid, // Read data valid
  output logic burnoutOn, // Both burnout sources on
  output logic auxConvCurrentCorrect, // Aux converter scaling enable
  output logic primaryConvCurrentCorrect, // Primary converter scaling enable
  output logic [1:0] excitationOutA, // Sources driving DAC-shared pin
  output logic [1:0] excitationOutB // Sources driving AIN5-shared pin
);
  ////////////////////////////////////////////////////////////////////////////
  logic wrHit;
  logic rdHit;
  logic [6:0] ctrlBits;
  logic [6:0] next_ctrlBits;
  ecc_pkg::ecc_ctrl_s ctrl;
  ecc_pkg::ecc_route_s route;
  logic [7:0] next_sfrRdata;
  logic next_sfrRdValid;
  logic next_burnoutOn;
  logic next_auxCorr;
  logic next_priCorr;
  logic [1:0] next_outA;
  logic [1:0] next_outB;

  ecc_sfr_decode uDecode (
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrRead(sfrRead),
    .sfrBitOp(sfrBitOp),
    .wrHit(wrHit),
    .rdHit(rdHit)
  );

  assign ctrl = ecc_pkg::ecc_ctrl_s'(ctrlBits);

  ecc_route uRoute (
    .ctrl(ctrl),
    .route(route)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next register and output values; bit 7 is never stored
  always_comb begin
    next_ctrlBits = ctrlBits;
    if (wrHit) begin
      next_ctrlBits = sfrWdata[6:0];
    end
    next_sfrRdata = 8'h00;
    if (rdHit) begin
      next_sfrRdata = {1'b0, ctrlBits};
    end
    next_sfrRdValid = rdHit;
    // Outputs follow the stored byte one cycle later, so they stay flop-driven
    next_burnoutOn = ctrl.burnoutOn;
    next_auxCorr = ctrl.auxConvCurrentCorrect;
    next_priCorr = ctrl.primaryConvCurrentCorrect;
    next_outA = route.excitationOutA;
    next_outB = route.excitationOutB;
  end

  // Registers; reset clears everything so all sources start off
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrlBits <= 7'(`ECC_CSC_RESET);
      sfrRdata <= 8'h00;
      sfrRdValid <= 1'b0;
      burnoutOn <= 1'b0;
      auxConvCurrentCorrect <= 1'b0;
      primaryConvCurrentCorrect <= 1'b0;
      excitationOutA <= 2'h0;
      excitationOutB <= 2'h0;
    end else begin
      ctrlBits <= next_ctrlBits;
      sfrRdata <= next_sfrRdata;
      sfrRdValid <= next_sfrRdValid;
      burnoutOn <= next_burnoutOn;
      auxConvCurrentCorrect <= next_auxCorr;
      primaryConvCurrentCorrect <= next_priCorr;
      excitationOutA <= next_outA;
      excitationOutB <= next_outB;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence byteWrite_s;
    wrHit;
  endsequence

  sequence byteRead_s;
    rdHit;
  endsequence

  sequence noWrite_s;
    !wrHit;
  endsequence

  sequence foreignWrite_s;
    sfrWrite && (sfrAddr != `ECC_CSC_ADDR);
  endsequence

  sequence bitWrite_s;
    sfrWrite && sfrBitOp;
  endsequence

  sequence bitRead_s;
    sfrRead && sfrBitOp;
  endsequence

  reset_clear_a: assert property (@(posedge mclk) $past(srst) |->
    (ctrlBits == 7'h00 && !burnoutOn && excitationOutA == 2'h0 && excitationOutB == 2'h0))
    else $error("control not cleared after reset");
  reserved_read_a: assert property (@(posedge mclk) disable iff (srst)
    sfrRdValid |-> !sfrRdata[7])
    else $error("reserved bit read as one");
  burnout_follow_a: assert property (@(posedge mclk) disable iff (srst)
    byteWrite_s |-> ##2 (burnoutOn == $past(sfrWdata[`ECC_BIT_BURNOUT], 2)))
    else $error("burnout not following write");
  aux_corr_a: assert property (@(posedge mclk) disable iff (srst)
    byteWrite_s |-> ##2 (auxConvCurrentCorrect == $past(sfrWdata[`ECC_BIT_AUX_CORR], 2)))
    else $error("aux correction not following write");
  pri_corr_a: assert property (@(posedge mclk) disable iff (srst)
    byteWrite_s |-> ##2 (primaryConvCurrentCorrect == $past(sfrWdata[`ECC_BIT_PRI_CORR], 2)))
    else $error("primary correction not following write");
  src2_route_a: assert property (@(posedge mclk) disable iff (srst)
    excitationOutA[1] |-> $past(ctrl.sourceTwoRouteSelect && ctrl.sourceTwoOn))
    else $error("source two on wrong pin");
  src1_route_a: assert property (@(posedge mclk) disable iff (srst)
    excitationOutB[0] |-> $past(ctrl.sourceOneRouteSelect && ctrl.sourceOneOn))
    else $error("source one on wrong pin");
  src2_on_a: assert property (@(posedge mclk) disable iff (srst)
    (excitationOutA[1] || excitationOutB[1]) == $past(ctrl.sourceTwoOn))
    else $error("source two enable mismatch");
  src1_on_a: assert property (@(posedge mclk) disable iff (srst)
    (excitationOutA[0] || excitationOutB[0]) == $past(ctrl.sourceOneOn))
    else $error("source one enable mismatch");
  stacked_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && sfrWdata[3:0] == 4'hB) |-> ##2 (excitationOutA == 2'h3))
    else $error("stacked sources blocked");
  read_back_a: assert property (@(posedge mclk) disable iff (srst)
    (rdHit && !$past(wrHit)) |=> (sfrRdata == {1'b0, $past(ctrlBits)}))
    else $error("read data differs from register");
  bit_op_a: assert property (@(posedge mclk) disable iff (srst)
    (sfrBitOp || !sfrWrite) |=> $stable(ctrlBits))
    else $error("register changed without byte write");

  ////////////////////////////////////////////////////////////////////////////
  // Reset behaviour, checked while reset is still held

  // Stored byte cleared one edge into reset
  reset_reg_a: assert property (@(posedge mclk)
    srst |=> (ctrlBits == 7'h00))
    else $error("register not cleared by reset");

  // Read path quiet during reset
  reset_outs_a: assert property (@(posedge mclk)
    srst |=> (sfrRdata == 8'h00 && !sfrRdValid))
    else $error("read path not cleared by reset");

  // Scaling enables off during reset
  reset_corr_a: assert property (@(posedge mclk)
    srst |=> (!auxConvCurrentCorrect && !primaryConvCurrentCorrect))
    else $error("correction enables not cleared by reset");

  // No current leaves the part during reset
  reset_pins_a: assert property (@(posedge mclk)
    srst |=> (excitationOutA == 2'h0 && excitationOutB == 2'h0 && !burnoutOn))
    else $error("current sources not off in reset");

  ////////////////////////////////////////////////////////////////////////////
  // Reserved bit

  // A one written to bit 7 leaves the other bits intact
  reserved_store_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && sfrWdata[7]) |=> (ctrlBits == $past(sfrWdata[6:0])))
    else $error("reserved bit disturbed the stored byte");

  // Idle read data never shows bit 7
  reserved_idle_a: assert property (@(posedge mclk) disable iff (srst)
    !sfrRdValid |-> !sfrRdata[7])
    else $error("reserved bit seen on idle bus");

  ////////////////////////////////////////////////////////////////////////////
  // Write acceptance

  // Byte write lands on the very next edge
  write_lands_a: assert property (@(posedge mclk) disable iff (srst)
    byteWrite_s |=> (ctrlBits == $past(sfrWdata[6:0])))
    else $error("byte write not stored");

  // Writes to other addresses leave the byte alone
  foreign_write_a: assert property (@(posedge mclk) disable iff (srst)
    foreignWrite_s |=> $stable(ctrlBits))
    else $error("foreign write changed register");

  // Bit-addressed writes are ignored; register is not bit-addressable
  bit_write_keep_a: assert property (@(posedge mclk) disable iff (srst)
    bitWrite_s |=> $stable(ctrlBits))
    else $error("bit write changed register");

  // Bit-addressed reads raise no valid
  bit_read_quiet_a: assert property (@(posedge mclk) disable iff (srst)
    bitRead_s |=> !sfrRdValid)
    else $error("bit read answered");

  // Bit-addressed reads leave the data bus at zero
  bit_data_zero_a: assert property (@(posedge mclk) disable iff (srst)
    bitRead_s |=> (sfrRdata == 8'h00))
    else $error("bit read drove data");

  ////////////////////////////////////////////////////////////////////////////
  // Read answer timing

  // Valid follows a byte read by exactly one cycle
  rd_valid_pulse_a: assert property (@(posedge mclk) disable iff (srst)
    byteRead_s |=> sfrRdValid)
    else $error("read not answered");

  // Valid only ever answers a read hit
  rd_valid_cause_a: assert property (@(posedge mclk) disable iff (srst)
    sfrRdValid |-> $past(rdHit))
    else $error("valid without read");

  // Data bus is zero whenever valid is low, so an OR-mux upstream stays clean
  rd_idle_zero_a: assert property (@(posedge mclk) disable iff (srst)
    !sfrRdValid |-> (sfrRdata == 8'h00))
    else $error("read data not zero when idle");

  ////////////////////////////////////////////////////////////////////////////
  // Outputs hold between writes; analog side sees no glitch

  // Burnout level steady when nothing was written
  burnout_hold_a: assert property (@(posedge mclk) disable iff (srst)
    noWrite_s |-> ##2 $stable(burnoutOn))
    else $error("burnout moved without write");

  // Aux scaling enable steady when nothing was written
  aux_hold_a: assert property (@(posedge mclk) disable iff (srst)
    noWrite_s |-> ##2 $stable(auxConvCurrentCorrect))
    else $error("aux correction moved without write");

  // Primary scaling enable steady when nothing was written
  pri_hold_a: assert property (@(posedge mclk) disable iff (srst)
    noWrite_s |-> ##2 $stable(primaryConvCurrentCorrect))
    else $error("primary correction moved without write");

  // DAC-shared pin drive steady when nothing was written
  pin_a_hold_a: assert property (@(posedge mclk) disable iff (srst)
    noWrite_s |-> ##2 $stable(excitationOutA))
    else $error("DAC pin drive moved without write");

  // Input-shared pin drive steady when nothing was written
  pin_b_hold_a: assert property (@(posedge mclk) disable iff (srst)
    noWrite_s |-> ##2 $stable(excitationOutB))
    else $error("input pin drive moved without write");

  ////////////////////////////////////////////////////////////////////////////
  // Routing and enables

  // Source one never lands on both pins
  src1_one_pin_a: assert property (@(posedge mclk) disable iff (srst)
    !(excitationOutA[0] && excitationOutB[0]))
    else $error("source one on both pins");

  // Source two never lands on both pins
  src2_one_pin_a: assert property (@(posedge mclk) disable iff (srst)
    !(excitationOutA[1] && excitationOutB[1]))
    else $error("source two on both pins");

  // Source one reaches the DAC pin only with its select clear
  src1_dac_a: assert property (@(posedge mclk) disable iff (srst)
    excitationOutA[0] |-> $past(ctrl.sourceOneOn && !ctrl.sourceOneRouteSelect))
    else $error("source one on DAC pin wrongly");

  // Source two reaches the input pin only with its select clear
  src2_ain_a: assert property (@(posedge mclk) disable iff (srst)
    excitationOutB[1] |-> $past(ctrl.sourceTwoOn && !ctrl.sourceTwoRouteSelect))
    else $error("source two on input pin wrongly");

  // Both sources may stack on the input-shared pin as well
  stacked_b_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && sfrWdata[3:0] == 4'h7) |-> ##2 (excitationOutB == 2'h3))
    else $error("stacked sources blocked on input pin");

  // Both enables clear means no excitation current anywhere
  src_off_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && sfrWdata[1:0] == 2'h0) |-> ##2 (excitationOutA == 2'h0 && excitationOutB == 2'h0))
    else $error("excitation on while disabled");

  // Burnout clear switches both burnout sources off
  burnout_off_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && !sfrWdata[`ECC_BIT_BURNOUT]) |-> ##2 !burnoutOn)
    else $error("burnout on while disabled");

  // Aux scaling off when its bit is written clear
  aux_off_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && !sfrWdata[`ECC_BIT_AUX_CORR]) |-> ##2 !auxConvCurrentCorrect)
    else $error("aux correction on while disabled");

  // Primary scaling off when its bit is written clear
  pri_off_a: assert property (@(posedge mclk) disable iff (srst)
    (wrHit && !sfrWdata[`ECC_BIT_PRI_CORR]) |-> ##2 !primaryConvCurrentCorrect)
    else $error("primary correction on while disabled");
endmodule

// ==== logic/ecc_regs.svh ====
// Register offset, field positions, reset value and drive constants for the current-source control
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_CSC_ADDR 8'hD5
`define ECC_CSC_RESET 8'h00
`define ECC_CSC_IMPL_MASK 8'h7F
`define ECC_BIT_BURNOUT 6
`define ECC_BIT_AUX_CORR 5
`define ECC_BIT_PRI_CORR 4
`define ECC_BIT_SRC2_ROUTE 3
`define ECC_BIT_SRC1_ROUTE 2
`define ECC_BIT_SRC2_ON 1
`define ECC_BIT_SRC1_ON 0
`define ECC_SOURCE_UA 200
`endif

// ==== logic/ecc_pkg.sv ====
// Types shared by the current-source control register files
package ecc_pkg;
  typedef struct packed {
    logic burnoutOn;
    logic auxConvCurrentCorrect;
    logic primaryConvCurrentCorrect;
    logic sourceTwoRouteSelect;
    logic sourceOneRouteSelect;
    logic sourceTwoOn;
    logic sourceOneOn;
  } ecc_ctrl_s;
  typedef struct packed {
    logic [1:0] excitationOutA;
    logic [1:0] excitationOutB;
  } ecc_route_s;
  typedef enum logic [1:0] {
    ECC_IDLE,
    ECC_WROTE,
    ECC_READ
  } ecc_acc_e;
endpackage

// ==== logic/ecc_sfr_decode.sv ====
// SFR bus decode for the current-source control byte
`timescale 1ns/1ps
`include "ecc_regs.svh"
module ecc_sfr_decode (
  input wire logic [7:0] sfrAddr, // SFR address
  input wire logic sfrWrite, // Byte write strobe
  input wire logic sfrRead, // Byte read strobe
  input wire logic sfrBitOp, // Bit-addressed access marker
  output logic wrHit, // Byte write to this register
  output logic rdHit // Byte read of this register
);
  // Bit-addressed cycles are never a hit: register is byte-only
  always_comb begin
    wrHit = sfrWrite && !sfrBitOp && (sfrAddr == `ECC_CSC_ADDR);
    rdHit = sfrRead && !sfrBitOp && (sfrAddr == `ECC_CSC_ADDR);
  end
endmodule

// ==== logic/ecc_route.sv ====
// Routing of the two excitation sources onto their pins
`timescale 1ns/1ps
module ecc_route (
  input wire ecc_pkg::ecc_ctrl_s ctrl, // Current control fields
  output ecc_pkg::ecc_route_s route // Per-pin source drive
);
  // Each pin gathers every enabled source routed to it; no exclusion, so both may stack
  always_comb begin
    route.excitationOutA[0] = ctrl.sourceOneOn && !ctrl.sourceOneRouteSelect;
    route.excitationOutB[0] = ctrl.sourceOneOn && ctrl.sourceOneRouteSelect;
    route.excitationOutA[1] = ctrl.sourceTwoOn && ctrl.sourceTwoRouteSelect;
    route.excitationOutB[1] = ctrl.sourceTwoOn && !ctrl.sourceTwoRouteSelect;
  end
endmodule

// ==== verif/ecc_core_model.sv ====
// Core-side model that issues byte and bit accesses on the SFR bus
`timescale 1ns/1ps
module ecc_core_model (
  input wire logic mclk, // Core clock
  input wire logic [7:0] sfrRdata, // Read data
  input wire logic sfrRdValid, // Read data valid
  output logic [7:0] sfrAddr, // Address
  output logic [7:0] sfrWdata, // Write data
  output logic sfrWrite, // Write strobe
  output logic sfrRead, // Read strobe
  output logic sfrBitOp // Bit access marker
);
  // Quiet bus at time zero
  initial begin
    {sfrAddr, sfrWdata, sfrWrite, sfrRead, sfrBitOp} = 19'h0;
  end
  // One-cycle access; idle bus shows inverted values so stale data never looks valid
  task acc(input logic w, input logic [7:0] a, d, input logic b, output logic [8:0] r);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= w;
    sfrRead <= !w;
    sfrBitOp <= b;
    @(posedge mclk);
    {sfrWrite, sfrRead, sfrBitOp} <= 3'h0;
    sfrAddr <= ~a;
    sfrWdata <= ~d;
    #1 r = {sfrRdValid, sfrRdata};
  endtask
endmodule

// ==== verif/ecc_tb.sv ====
// Randomised self-checking bench for the current-source control register
`timescale 1ns/1ps
`include "ecc_regs.svh"
module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, shadow, addr, data;
  logic sfrWrite, sfrRead, sfrBitOp, sfrRdValid, burnoutOn, auxCc, priCc;
  logic [1:0] outA, outB;
  logic [8:0] got, obs;
  logic [7:0] corner [5] = '{8'h4B, 8'h07, 8'hFF, 8'h03, 8'h8C};
  int nErrors = 0;
  int testsRun = 0;
  int kind;
  ////////////////////////////////////////////////////////////////
  // Clock and observed control outputs
  always #5 mclk = ~mclk;
  assign obs = {2'h0, burnoutOn, auxCc, priCc, outA, outB};
  ecc_current_ctrl DUT (.mclk(mclk), .srst(srst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrBitOp(sfrBitOp), .sfrRdata(sfrRdata),
    .sfrRdValid(sfrRdValid), .burnoutOn(burnoutOn), .auxConvCurrentCorrect(auxCc),
    .primaryConvCurrentCorrect(priCc), .excitationOutA(outA), .excitationOutB(outB));
  ecc_core_model cm (.mclk(mclk), .sfrRdata(sfrRdata), .sfrRdValid(sfrRdValid),
    .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrBitOp(sfrBitOp));
  ////////////////////////////////////////////////////////////////
  // Pin drive expected from a register value; both sources may stack
  function logic [8:0] expOut(input logic [7:0] r);
    return {2'h0, r[6], r[5], r[4], r[1] & r[3], r[0] & ~r[2], r[1] & ~r[3], r[0] & r[2]};
  endfunction
  task chk(input string nm, input logic [8:0] e, g);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    if (nErrors == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Corners first, then random writes: byte, bit-op or foreign address
  initial begin
    kind = $urandom(32'h64515bb8);
    shadow = 8'h00;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    #1 chk("controls", 9'h000, obs);
    for (int i = 0; i < 60; i++) begin
      data = (i < 5) ? corner[i] : 8'($urandom);
      kind = (i < 5) ? 3 : int'($urandom % 4);
      addr = (kind == 1) ? 8'($urandom) : `ECC_CSC_ADDR;
      if (kind == 1 && addr == `ECC_CSC_ADDR) addr = 8'hD4;
      cm.acc(1'b1, addr, data, kind == 0, got);
      if (kind > 1) shadow = data & 8'h7F;
      @(posedge mclk);
      #1 chk("controls", expOut(shadow), obs);
      cm.acc(1'b0, `ECC_CSC_ADDR, 8'h00, kind == 0 && i[0], got);
      chk("readback", (kind == 0 && i[0]) ? 9'h000 : {1'b1, shadow}, got);
    end
    // Second reset in mid-run must clear everything again
    @(posedge mclk) srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1 chk("controls", 9'h000, obs);
    cm.acc(1'b0, `ECC_CSC_ADDR, 8'h00, 1'b0, got);
    chk("readback", 9'h100, got);
    conclude;
  end
  // Watchdog well beyond the expected few microseconds
  initial begin
    #20000;
    nErrors++;
    conclude;
  end
endmodule
